//--- src/sps_sequencer.sv
// Stepper phase sequencer: step-clock decoding, phase state, APB status.
// Assumes all pins are asynchronous to pclk and step clocks are slow.
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module sps_sequencer
  import sps_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [sps_pkg::SPS_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  step_clock_first,
  input  wire logic                  step_clock_second,
  input  wire logic                  rotation_direction_select,
  input  wire logic                  excitation_select_a,
  input  wire logic                  excitation_select_b,
  input  wire logic                  three_phase_select,
  input  wire logic                  output_gate,
  output logic      [3:0]            phase_out,
  output logic                       initial_state_monitor,
  output logic                       step_clock_echo
);
  import sps_pkg::*;

  // Overview of the datapath:
  // - every pin passes two flip-flops before any logic reads it
  // - a step edge is seen three pclk edges after the pin rises
  // - the phase position moves on that edge, outputs one edge later
  // - the echo output rises with the position update
  // - the echo falls once the accepted step clock is seen low
  // Limitations:
  // - step pulses shorter than a few pclk periods are lost
  // - both clocks rising in one pclk period give a CW step
  // - mode pins are only safe to change while reset is held
  // - the soft reset bit holds the position just like the pin
  // Trade-off: the pin reset also clears the synchronisers, so a
  // pin change made during reset shows up two edges after release.
  // The step clocks restart from their idle high level, so the
  // release itself never looks like a rising step edge.

  // Two-stage synchronisers for all seven pins
  logic [6:0] sync1_reg;
  logic [6:0] sync2_reg;
  logic [1:0] ck_prev_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg   <= SPS_SYNC_RST;
      sync2_reg   <= SPS_SYNC_RST;
      ck_prev_reg <= SPS_CK_IDLE; // No false edge after reset
    end else begin
      sync1_reg   <= {output_gate, three_phase_select, excitation_select_b,
                      excitation_select_a, rotation_direction_select,
                      step_clock_second, step_clock_first};
      sync2_reg   <= sync1_reg;
      ck_prev_reg <= sync2_reg[1:0];
    end
  end

  // Synchronised pin levels
  logic      sclk_a;
  logic      sclk_b;
  logic      dir_hi;
  logic      three;
  logic      gate;
  sps_mode_e mode;
  assign sclk_a = sync2_reg[0];
  assign sclk_b = sync2_reg[1];
  assign dir_hi = sync2_reg[2];
  assign mode   = sps_mode_e'({sync2_reg[4], sync2_reg[3]});
  assign three  = sync2_reg[5];
  assign gate   = sync2_reg[6];

  // Edge decode; inhibit combinations are simply ignored
  // A rise only counts while the other clock is seen high
  logic rise1;
  logic rise2;
  logic step_cw;
  logic step_ccw;
  logic step_any;
  assign rise1    = sclk_a & ~ck_prev_reg[0];
  assign rise2    = sclk_b & ~ck_prev_reg[1];
  assign step_cw  = dir_hi ? (rise2 & sclk_a) : (rise1 & sclk_b);
  assign step_ccw = dir_hi ? (rise1 & sclk_b) : (rise2 & sclk_a);
  assign step_any = step_cw | step_ccw;

  // Software reset bit acts like the reset pin on the phase state
  logic [31:0] ctrl_reg;
  logic        srst;
  assign srst = ctrl_reg[SPS_CTRL_SRST];

  // Positions count half steps around one pattern cycle.
  // Wrap is done by one subtraction, enough as stride <= 2.
  // Next position; one-phase and two-phase skip odd half steps
  logic [3:0] len;
  logic [3:0] stride;
  logic [2:0] pos_reg;
  logic [2:0] pos_next;
  logic [3:0] up;
  logic [3:0] dn;
  always_comb begin
    len    = three ? SPS_LEN_THREE : SPS_LEN_FOUR;
    stride = (mode == SPS_MODE_HALF) ? 4'h1 : 4'h2;
    up     = {1'b0, pos_reg} + stride;
    dn     = {1'b0, pos_reg} + len - stride;
    if (up >= len) up = up - len;
    if (dn >= len) dn = dn - len;
    pos_next = pos_reg;
    if (step_cw) pos_next = up[2:0];
    else if (step_ccw) pos_next = dn[2:0];
  end

  // Phase state; reset is asynchronous to the step clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_reg <= SPS_POS_INIT;
    end else if (srst) begin
      pos_reg <= SPS_POS_INIT;
    end else begin
      pos_reg <= pos_next;
    end
  end

  // Two-phase mode shifts the pattern by one half step, so the
  // initial state already drives two adjacent phases.
  // Half-step pattern: even is one phase, odd is two adjacent
  function automatic logic [3:0] sps_pattern(input logic [2:0] p,
                                             input logic       thr,
                                             input sps_mode_e  m);
    logic [3:0] h;
    logic [1:0] k;
    logic [1:0] kn;
    logic [3:0] pat;
    h = {1'b0, p} + ((m == SPS_MODE_TWO) ? 4'h1 : 4'h0);
    if (thr && h >= SPS_LEN_THREE) h = h - SPS_LEN_THREE;
    if (!thr && h >= SPS_LEN_FOUR) h = h - SPS_LEN_FOUR;
    k   = h[2:1];
    kn  = (thr && k == 2'd2) ? 2'd0 : k + 2'd1;
    pat = 4'h1 << k;
    if (h[0]) pat = pat | (4'h1 << kn);
    return pat;
  endfunction

  // Registered outputs; gate hides the pattern but not the state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_out             <= 4'h0;
      initial_state_monitor <= 1'b0;
    end else begin
      if (!gate) phase_out <= 4'h0;
      else if (mode == SPS_MODE_TEST) phase_out <= 4'hF;
      else phase_out <= sps_pattern(pos_reg, three, mode);
      initial_state_monitor <= (pos_reg != SPS_POS_INIT) && !srst;
    end
  end

  // Echo follows the accepted clock until that clock falls
  logic echo_src_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_clock_echo <= 1'b0;
      echo_src_reg    <= 1'b0;
    end else if (step_any && !srst) begin
      step_clock_echo <= 1'b1;
      echo_src_reg    <= rise2;
    end else if (echo_src_reg ? !sclk_b : !sclk_a) begin
      step_clock_echo <= 1'b0;
    end
  end

  // APB slave: zero wait states, answer one cycle after setup
  // Read data and error are registered at the setup edge, so
  // they stand for the single access cycle that follows.
  logic setup;
  logic hit_ctrl;
  logic hit_stat;
  assign setup    = psel & ~penable;
  assign hit_ctrl = (paddr == SPS_CTRL_OFS);
  assign hit_stat = (paddr == SPS_STATUS_OFS);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit_ctrl & ~(hit_stat & ~pwrite);
      prdata  <= 32'h0000_0000;
      if (setup && !pwrite && hit_ctrl) prdata <= ctrl_reg;
      if (setup && !pwrite && hit_stat) begin
        prdata[SPS_ST_POS_LSB +: 3]   <= pos_reg;
        prdata[SPS_ST_PHASE_LSB +: 4] <= phase_out;
        prdata[SPS_ST_MON]            <= initial_state_monitor;
        prdata[SPS_ST_MODE_LSB +: 2]  <= mode;
        prdata[SPS_ST_THREE]          <= three;
      end
    end
  end

  // Only the soft reset bit is kept; other bits read as zero.
  // Control write lands at the access edge only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= SPS_CTRL_RST;
    end else if (psel && penable && pready && pwrite && hit_ctrl) begin
      ctrl_reg <= {31'h0000_0000, pwdata[SPS_CTRL_SRST]};
    end
  end
endmodule // sps_sequencer
`default_nettype wire

//--- src/sps_pkg.sv
// Constants and types for the stepper phase sequencer.
// Assumes a single pclk domain; pins are synchronised by the top module.
//
// Functional notes
// - Rise on first clock, second high: CW; mirrored CCW; direction swaps.
// - A/B pick 1-, 2- or 1-2-phase; phase-count high means three-phase.
// - Both excitation selects high is test mode, all phase outputs on.
// - Reset low forces the phase state to initial, asynchronously.
// - Monitor output low in initial state, including reset, high otherwise.
// - After reset release, first valid step edge moves to next state.
// - Phase outputs on only while output gate high; state kept when low.
package sps_pkg;
  // Excitation mode, decoded from the two select pins
  typedef enum logic [1:0] {
    SPS_MODE_ONE  = 2'b00,
    SPS_MODE_TWO  = 2'b01,
    SPS_MODE_HALF = 2'b10,
    SPS_MODE_TEST = 2'b11
  } sps_mode_e;

  localparam int          SPS_ADDR_W      = 4;
  localparam logic [3:0]  SPS_CTRL_OFS    = 4'h0;
  localparam logic [3:0]  SPS_STATUS_OFS  = 4'h4;
  localparam int          SPS_CTRL_SRST   = 0;
  localparam logic [31:0] SPS_CTRL_RST    = 32'h0000_0000;
  // Status field positions
  localparam int          SPS_ST_POS_LSB  = 0;
  localparam int          SPS_ST_PHASE_LSB = 4;
  localparam int          SPS_ST_MON      = 8;
  localparam int          SPS_ST_MODE_LSB = 9;
  localparam int          SPS_ST_THREE    = 11;
  // Half-step positions per revolution of the phase pattern
  localparam logic [3:0]  SPS_LEN_FOUR    = 4'h8;
  localparam logic [3:0]  SPS_LEN_THREE   = 4'h6;
  localparam logic [2:0]  SPS_POS_INIT    = 3'h0;
  // Synchroniser reset: step clocks idle high, other pins low
  localparam logic [6:0]  SPS_SYNC_RST    = 7'h03;
  localparam logic [1:0]  SPS_CK_IDLE     = 2'h3;
endpackage

//--- tb/sps_assertions.sv
// Checker on sequencer ports: APB timing, gate, test mode, echo.
// Bound to sps_sequencer; one pclk domain.
`timescale 1ns/100ps
`default_nettype none
module sps_chk
  import sps_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [3:0] paddr,
  input wire logic [3:0] phase_out,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       output_gate,
  input wire logic       step_clock_first,
  input wire logic       step_clock_second,
  input wire logic       excitation_select_a,
  input wire logic       excitation_select_b,
  input wire logic       initial_state_monitor,
  input wire logic       step_clock_echo
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus phases
  sequence s_setup; psel && !penable; endsequence
  sequence s_take; psel && penable && pready; endsequence
  a_pready_next: assert property (s_setup |=> pready)
    else $error("pready late");
  a_pready_one: assert property (s_take |=> !pready)
    else $error("pready held");
  a_slverr_map: assert property (s_take |-> pslverr == (paddr !=
    SPS_CTRL_OFS && (pwrite || paddr != SPS_STATUS_OFS)))
    else $error("pslverr wrong");
  a_mon_release: assert property ($rose(presetn) |->
    !initial_state_monitor) else $error("monitor high at release");
  a_gate_off: assert property ((!output_gate)[*4] |->
    phase_out == 4'h0) else $error("phases on with gate low");
  a_test_on: assert property ((excitation_select_a &&
    excitation_select_b && output_gate)[*6] |-> phase_out == 4'hF)
    else $error("test mode not all on");
  a_echo_cause: assert property ($rose(step_clock_echo) |->
    $past(step_clock_first && step_clock_second, 2))
    else $error("echo without step");
  a_mon_step: assert property ($rose(initial_state_monitor) |->
    $past(step_clock_echo)) else $error("monitor moved without step");
endmodule // sps_chk
bind sps_sequencer sps_chk u_chk (.*);
`default_nettype wire

//--- tb/sps_host.sv
// Host model: step clocks and mode pins of the sequencer.
// Called from the bench just after a rising pclk edge.
`timescale 1ns/100ps
`default_nettype none
module sps_host (
  input  wire logic pclk,
  output logic      host_rst_n,
  output logic      step_clock_first,
  output logic      step_clock_second,
  output logic      rotation_direction_select,
  output logic      three_phase_select,
  output logic      excitation_select_a,
  output logic      excitation_select_b
);
  initial {host_rst_n, step_clock_first, step_clock_second} = 3'h7;
  initial {rotation_direction_select, three_phase_select} = 2'h0;
  initial {excitation_select_a, excitation_select_b} = 2'h0;
  // Low then high while the other stays high: never inhibit
  task automatic step(input logic sec);
    @(posedge pclk);
    {step_clock_first, step_clock_second} <= sec ? 2'b10 : 2'b01;
    repeat (6) @(posedge pclk);
    {step_clock_first, step_clock_second} <= 2'b11;
    repeat (6) @(posedge pclk);
  endtask
  // Reset spans every mode change; mostly four-phase use
  task automatic mode(input logic [3:0] m);
    @(posedge pclk);
    host_rst_n <= 1'b0;
    {excitation_select_a, excitation_select_b, three_phase_select,
      rotation_direction_select} <= m;
    repeat (4) @(posedge pclk);
    host_rst_n <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask
endmodule // sps_host
`default_nettype wire

//--- tb/tb.sv
// Bench: host model and APB master around the sequencer.
// Inputs change by NBA after rising edges; run ends in close_out.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import sps_pkg::*;
  logic pclk = 1'b0, por_n = 1'b0, host_rst_n, presetn, err;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [3:0] paddr = 4'h0, phase_out;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic step_clock_first, step_clock_second, rotation_direction_select;
  logic excitation_select_a, excitation_select_b, three_phase_select;
  logic output_gate = 1'b1, initial_state_monitor, step_clock_echo;
  int fail_count = 0, comparisons = 0, cyc = 0;
  assign presetn = por_n & host_rst_n;
  sps_sequencer dut (.*);
  sps_host u_host (.*);
  always #4 pclk = ~pclk;
  task automatic check(input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [3:0] a, input int d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // Mode, step clock, start pattern, pattern after one step
  task automatic t_modes;
    logic [15:0] tb_l [8] = '{16'h0012, 16'h1018, 16'h0118, 16'h8036,
      16'h4013, 16'h2114, 16'hC0FF, 16'hE0FF};
    foreach (tb_l[i]) begin
      u_host.mode(tb_l[i][15:12]);
      check(phase_out, tb_l[i][7:4]);
      check(initial_state_monitor, 1'b0);
      u_host.step(tb_l[i][8]);
      check(phase_out, tb_l[i][3:0]);
      check(step_clock_echo, 1'b1);
      if (tb_l[i][15:14] != 2'b11) check(initial_state_monitor, 1'b1);
    end
  endtask
  // Gate low blanks outputs, yet the step still lands
  task automatic t_gate;
    u_host.mode(4'h0);
    output_gate <= 1'b0;
    u_host.step(1'b0);
    check(phase_out, 4'h0);
    output_gate <= 1'b1;
    repeat (5) @(posedge pclk);
    check(phase_out, 4'h2);
  endtask
  // Status read, unmapped refusal, soft reset to initial
  task automatic t_apb;
    apb(1'b0, SPS_STATUS_OFS, 0);
    check({err, rd[SPS_ST_MON], rd[SPS_ST_PHASE_LSB +: 4]}, 6'h12);
    apb(1'b1, 4'h8, 1);
    check(err, 1'b1);
    apb(1'b1, SPS_CTRL_OFS, 1);
    repeat (3) @(posedge pclk);
    check({err, initial_state_monitor}, 2'b00);
    apb(1'b1, SPS_CTRL_OFS, 0);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    check(initial_state_monitor, 1'b0);
    por_n <= 1'b1;
    t_modes;
    t_gate;
    t_apb;
    close_out;
  end
  // Ceiling far above the few hundred cycles needed
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      close_out;
    end
  end
endmodule // tb
`default_nettype wire
